// ==== rtl/sic_top.sv ====
// Status indicator controller: display, LEDs and register port.
`timescale 1ns/100ps
module sic_top import sic_pkg::*; #(
	parameter int          DIGITS      = 3,
	parameter int          NPORTS      = 2,
	parameter int unsigned TICK_CYCLES = SIC_TICK_CYCLES
) (
	input  logic                    ref_clk,
	input  logic                    resetn,
	input  sic_status_t             status,
	input  logic [NPORTS-1:0]       port_link,
	input  logic [NPORTS-1:0]       port_line_err,
	input  logic [7:0]              bus_addr,
	input  logic [31:0]             bus_wdata,
	input  logic                    bus_wr,
	input  logic                    bus_rd,
	output logic [31:0]             bus_rdata,
	output logic                    irq,
	output logic [DIGITS-1:0][4:0]  disp_char,
	output logic [DIGITS-1:0]       disp_dp,
	output logic                    operating_led,
	output logic                    fault_network_led,
	output logic                    safety_ready_led,
	output logic [NPORTS-1:0]       link_led,
	output logic [NPORTS-1:0]       line_error_led
);

	localparam int TICK_W = $clog2(TICK_CYCLES);

	sic_view_t             view;        // Current display view.
	logic [TICK_W-1:0]     tick_cnt;    // Millisecond divider.
	logic                  ms_tick;     // One-cycle ms enable.
	logic [SIC_MS_W-1:0]   blink_cnt;   // Blink half period count.
	logic                  blink_hit;   // Half period elapsed.
	logic                  blink_phase; // Blink on/off phase.
	logic [SIC_MS_W-1:0]   dwell_cnt;   // Alternation dwell count.
	logic                  dwell_hit;   // Dwell elapsed.
	logic [SIC_MS_W-1:0]   cfg_pend;    // Written, not yet applied.
	logic [SIC_MS_W-1:0]   cfg_act;     // Applied blink half period.
	logic                  soft_rst;    // Software reset pulse.
	logic [SIC_INT_W-1:0]  int_stat;    // Sticky event bits.
	logic [SIC_INT_W-1:0]  int_mask;    // Interrupt enables.
	logic [SIC_INT_W-1:0]  events;      // Event pulses this cycle.
	logic                  alarm_q;     // Alarm one cycle ago.
	logic                  warn_q;      // Warning one cycle ago.
	logic [NPORTS-1:0]     link_s1;     // Link synchroniser stage 1.
	logic [NPORTS-1:0]     link_s2;     // Link synchroniser stage 2.
	logic [NPORTS-1:0]     link_s3;     // Link synchroniser stage 3.
	logic [NPORTS-1:0]     link_st;     // Debounced link level.
	logic [NPORTS-1:0]     lerr_s1;     // Error synchroniser stage 1.
	logic [NPORTS-1:0]     lerr_s2;     // Error synchroniser stage 2.
	logic [NPORTS-1:0]     lerr_s3;     // Error synchroniser stage 3.
	logic [NPORTS-1:0]     lerr_st;     // Debounced line error level.
	logic [NPORTS-1:0]     link_chg;    // Debounced link changes.
	logic                  show_ip;     // Connected and operational.
	logic                  any_alm;     // Alarm or warning active.
	logic [4:0]            net_code;    // Leading network pattern.

	// Leading pattern: special states first, then network state.
	always_comb begin
		show_ip  = 1'b0;
		net_code = SIC_CH_ONLINE;
		if (status.cpu_wdt_err) begin
			net_code = SIC_CH_CPUERR;
		end else if (status.fw_updating) begin
			net_code = SIC_CH_UPDATE;
		end else if (status.param_init) begin
			net_code = SIC_CH_INIT;
		end else if (status.ip_setting) begin
			net_code = SIC_CH_IPSET;
		end else if (status.test_mode) begin
			net_code = SIC_CH_TEST;
		end else if (!status.ctrl_connected) begin
			net_code = SIC_CH_NOCTRL;
		end else if (!status.data_linked) begin
			net_code = SIC_CH_NOLINK;
		end else if (status.reserved_stn) begin
			net_code = SIC_CH_RSVD;
		end else if (status.nm_preop) begin
			net_code = SIC_CH_PREOP;
		end else if (status.nm_safeop) begin
			net_code = SIC_CH_SAFEOP;
		end else begin
			show_ip = 1'b1;
		end
	end

	assign any_alm = status.alarm | status.warning;

	// Builds one display frame for the given view.
	function automatic logic [DIGITS-1:0][4:0] frame(
		input sic_view_t   v,
		input logic [4:0]  code,
		input logic        ip,
		input sic_status_t st
	);
		logic [DIGITS-1:0][4:0] f;
		f = '0;
		for (int i = 0; i < DIGITS; i++) begin
			case (v)
				SIC_BOOT: begin
					f[i] = SIC_CH_BOOT;
				end
				SIC_ALM: begin
					// Alarm code nibbles, low digit rightmost.
					if (i < 3) begin
						f[i] = {1'b0, st.alarm_code[i*4 +: 4]};
					end else begin
						f[i] = SIC_CH_ALARM;
					end
				end
				default: begin
					// Octet four in hex on the last two digits.
					if (ip && i < 2) begin
						f[i] = {1'b0, st.ip_octet4[i*4 +: 4]};
					end else if (i == DIGITS-1) begin
						f[i] = code;
					end else begin
						f[i] = ip ? code : SIC_CH_DASH;
					end
				end
			endcase
		end
		return f;
	endfunction

	// Register read decode for the plain port.
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		case (a)
			SIC_CFG_PEND: reg_read = 32'(cfg_pend);
			SIC_CFG_ACT:  reg_read = 32'(cfg_act);
			SIC_STATE:    reg_read = 32'({lerr_st, link_st,
				safety_ready_led, fault_network_led,
				operating_led, blink_phase, view});
			SIC_INT_STAT: reg_read = 32'(int_stat);
			SIC_INT_MASK: reg_read = 32'(int_mask);
			default:      reg_read = 32'h0000_0000;
		endcase
	endfunction

	// Millisecond enable from the clock divider.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b0;
		end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			ms_tick  <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			ms_tick  <= 1'b0;
		end
	end

	// Blink half period counted in ms from the applied setting.
	assign blink_hit = ms_tick && (blink_cnt + 1'b1 >= cfg_act);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			blink_cnt   <= '0;
			blink_phase <= 1'b0;
		end else if (blink_hit) begin
			blink_cnt   <= '0;
			blink_phase <= ~blink_phase;
		end else if (ms_tick) begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	// Dwell timer paces the network/alarm alternation.
	assign dwell_hit = ms_tick && (dwell_cnt + 1'b1 >= SIC_DWELL_MS);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dwell_cnt <= '0;
		end else if (dwell_hit || view == SIC_BOOT) begin
			dwell_cnt <= '0;
		end else if (ms_tick) begin
			dwell_cnt <= dwell_cnt + 1'b1;
		end
	end

	// View sequencing: boot, then network, alternating with alarm.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			view <= SIC_BOOT;
		end else if (soft_rst) begin
			view <= SIC_BOOT;
		end else begin
			case (view)
				SIC_BOOT: begin
					// Hold until the check is done and amp started.
					if (status.sys_check_done &&
						status.amp_started) begin
						view <= SIC_NET;
					end
				end
				SIC_NET: begin
					if (any_alm && dwell_hit) begin
						view <= SIC_ALM;
					end
				end
				SIC_ALM: begin
					if (!any_alm || dwell_hit) begin
						view <= SIC_NET;
					end
				end
				default: begin
					view <= SIC_BOOT;
				end
			endcase
		end
	end

	// Display characters and servo-state decimal points.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			disp_char <= '0;
			disp_dp   <= '0;
		end else begin
			disp_char <= frame(view, net_code, show_ip, status);
			disp_dp   <= '0;
			if (view != SIC_BOOT) begin
				disp_dp[SIC_DP_ON]  <= status.servo_on;
				disp_dp[SIC_DP_RDY] <= status.servo_ready;
			end
		end
	end

	// Port pins pass three flops; a change counts when 2 and 3 agree.
	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				link_s1[p] <= 1'b0;
				link_s2[p] <= 1'b0;
				link_s3[p] <= 1'b0;
				link_st[p] <= 1'b0;
				lerr_s1[p] <= 1'b0;
				lerr_s2[p] <= 1'b0;
				lerr_s3[p] <= 1'b0;
				lerr_st[p] <= 1'b0;
			end else begin
				link_s1[p] <= port_link[p];
				link_s2[p] <= link_s1[p];
				link_s3[p] <= link_s2[p];
				lerr_s1[p] <= port_line_err[p];
				lerr_s2[p] <= lerr_s1[p];
				lerr_s3[p] <= lerr_s2[p];
				if (link_s2[p] == link_s3[p]) begin
					link_st[p] <= link_s3[p];
				end
				if (lerr_s2[p] == lerr_s3[p]) begin
					lerr_st[p] <= lerr_s3[p];
				end
			end
		end
		assign link_chg[p] = (link_s2[p] == link_s3[p]) &&
			(link_s3[p] != link_st[p]);
	end

	// LED drivers.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			operating_led     <= 1'b0;
			fault_network_led <= 1'b0;
			safety_ready_led  <= 1'b0;
			link_led          <= '0;
			line_error_led    <= '0;
		end else begin
			operating_led <= status.amp_on && !status.alarm;
			if (status.alarm) begin
				fault_network_led <= 1'b1;
			end else if (status.warning) begin
				fault_network_led <= blink_phase;
			end else begin
				fault_network_led <= 1'b0;
			end
			safety_ready_led <= status.safety_ok;
			link_led         <= link_st;
			line_error_led   <= lerr_st;
		end
	end

	// Configuration: pending applies only at a software reset.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_pend <= SIC_BLINK_MS;
			cfg_act  <= SIC_BLINK_MS;
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= bus_wr && bus_addr == SIC_CTRL &&
				bus_wdata[SIC_CTRL_SRST];
			if (bus_wr && bus_addr == SIC_CFG_PEND) begin
				cfg_pend <= bus_wdata[SIC_MS_W-1:0];
			end
			if (soft_rst) begin
				cfg_act <= cfg_pend;
			end
		end
	end

	// Interrupt events: rising alarm/warning, link change, ready.
	always_comb begin
		events                = '0;
		events[SIC_INT_ALARM] = status.alarm && !alarm_q;
		events[SIC_INT_WARN]  = status.warning && !warn_q;
		events[SIC_INT_LINKA] = link_chg[0];
		events[SIC_INT_LINKB] = link_chg[NPORTS-1];
		events[SIC_INT_READY] = view == SIC_BOOT &&
			status.sys_check_done && status.amp_started && !soft_rst;
	end

	// Sticky status, write one to clear; a new event wins.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			int_stat <= '0;
			int_mask <= '0;
			alarm_q  <= 1'b0;
			warn_q   <= 1'b0;
			irq      <= 1'b0;
		end else begin
			alarm_q <= status.alarm;
			warn_q  <= status.warning;
			if (bus_wr && bus_addr == SIC_INT_STAT) begin
				int_stat <= (int_stat &
					~bus_wdata[SIC_INT_W-1:0]) | events;
			end else begin
				int_stat <= int_stat | events;
			end
			if (bus_wr && bus_addr == SIC_INT_MASK) begin
				int_mask <= bus_wdata[SIC_INT_W-1:0];
			end
			irq <= |(int_stat & int_mask);
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bus_rdata <= '0;
		end else if (bus_rd) begin
			bus_rdata <= reg_read(bus_addr);
		end else begin
			bus_rdata <= '0;
		end
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// The boot view holds until the amplifier is ready.
	sequence s_not_ready;
		view == SIC_BOOT && !soft_rst &&
		!(status.sys_check_done && status.amp_started);
	endsequence

	// Network view with pending alarm meeting its dwell end.
	sequence s_alm_due;
		view == SIC_NET && any_alm && dwell_hit && !soft_rst;
	endsequence

	boot_hold_a: assert property (s_not_ready |=> view == SIC_BOOT)
		else $error("boot view left before ready");
	ip_digits_a: assert property (view == SIC_NET && show_ip |=>
		disp_char[0] == {1'b0, $past(status.ip_octet4[3:0])} &&
		disp_char[1] == {1'b0, $past(status.ip_octet4[7:4])})
		else $error("ip octet not on last digits");
	alarm_seq_a: assert property (s_alm_due |=> view == SIC_ALM)
		else $error("alarm view not entered");
	servo_dp_a: assert property (view != SIC_BOOT |=>
		disp_dp[SIC_DP_ON] == $past(status.servo_on))
		else $error("servo decimal point wrong");
	cpu_err_a: assert property (view == SIC_NET &&
		status.cpu_wdt_err |=>
		disp_char[DIGITS-1] == SIC_CH_CPUERR)
		else $error("watchdog pattern missing");
	link_led_a: assert property ($rose(link_st[0]) |=> link_led[0])
		else $error("link led not lit");
	line_err_a: assert property (lerr_st[0] |=> line_error_led[0])
		else $error("line error led dark");
	run_led_a: assert property (status.alarm |=> !operating_led)
		else $error("operating led lit on alarm");
	fault_on_a: assert property (status.alarm && status.warning
		|=> fault_network_led)
		else $error("fault led not steady on alarm");
	fault_off_a: assert property (!any_alm |=> !fault_network_led)
		else $error("fault led lit without cause");
	safety_led_a: assert property (status.safety_ok |=>
		safety_ready_led)
		else $error("safety led dark");
	cfg_hold_a: assert property (!soft_rst |=> $stable(cfg_act))
		else $error("config applied without reset");
	blink_rate_a: assert property ($changed(blink_phase) |->
		$past(blink_hit))
		else $error("blink toggled off its period");

endmodule

// ==== shared/sic_pkg.sv ====
// Constants and types of the status indicator controller.
package sic_pkg;

	// Clock rate and the millisecond tick derived from it.
	localparam int unsigned SIC_CLK_HZ      = 40_000_000;
	localparam int unsigned SIC_TICK_MS     = 1;
	localparam int unsigned SIC_TICK_CYCLES =
		SIC_CLK_HZ / 1000 * SIC_TICK_MS;

	// Blink half period and alarm alternation dwell, in ms.
	localparam int          SIC_MS_W        = 16;
	localparam logic [15:0] SIC_BLINK_MS    = 16'h01f4;
	localparam logic [15:0] SIC_DWELL_MS    = 16'h03e8;

	// Register byte offsets.
	localparam logic [7:0] SIC_CFG_PEND = 8'h00;
	localparam logic [7:0] SIC_CFG_ACT  = 8'h04;
	localparam logic [7:0] SIC_CTRL     = 8'h08;
	localparam logic [7:0] SIC_STATE    = 8'h0c;
	localparam logic [7:0] SIC_INT_STAT = 8'h10;
	localparam logic [7:0] SIC_INT_MASK = 8'h14;

	// Control bit that requests a software reset.
	localparam int SIC_CTRL_SRST = 0;

	// Interrupt status bits.
	localparam int SIC_INT_ALARM = 0;
	localparam int SIC_INT_WARN  = 1;
	localparam int SIC_INT_LINKA = 2;
	localparam int SIC_INT_LINKB = 3;
	localparam int SIC_INT_READY = 4;
	localparam int SIC_INT_W     = 5;

	// Decimal point positions for the servo state.
	localparam int SIC_DP_ON  = 0;
	localparam int SIC_DP_RDY = 1;

	// Character codes; 0 to 15 are hexadecimal digits.
	localparam logic [4:0] SIC_CH_BOOT   = 5'h10;
	localparam logic [4:0] SIC_CH_DASH   = 5'h11;
	localparam logic [4:0] SIC_CH_NOCTRL = 5'h12;
	localparam logic [4:0] SIC_CH_NOLINK = 5'h13;
	localparam logic [4:0] SIC_CH_PREOP  = 5'h14;
	localparam logic [4:0] SIC_CH_SAFEOP = 5'h15;
	localparam logic [4:0] SIC_CH_RSVD   = 5'h16;
	localparam logic [4:0] SIC_CH_TEST   = 5'h17;
	localparam logic [4:0] SIC_CH_CPUERR = 5'h18;
	localparam logic [4:0] SIC_CH_UPDATE = 5'h19;
	localparam logic [4:0] SIC_CH_INIT   = 5'h1a;
	localparam logic [4:0] SIC_CH_IPSET  = 5'h1b;
	localparam logic [4:0] SIC_CH_ONLINE = 5'h1c;
	localparam logic [4:0] SIC_CH_ALARM  = 5'h1d;

	// Display views.
	typedef enum logic [1:0] {
		SIC_BOOT,
		SIC_NET,
		SIC_ALM
	} sic_view_t;

	// Status inputs from the amplifier's own logic.
	typedef struct packed {
		logic        sys_check_done;
		logic        amp_started;
		logic        amp_on;
		logic        ctrl_connected;
		logic        data_linked;
		logic        nm_preop;
		logic        nm_safeop;
		logic        reserved_stn;
		logic        test_mode;
		logic        cpu_wdt_err;
		logic        fw_updating;
		logic        param_init;
		logic        ip_setting;
		logic        alarm;
		logic        warning;
		logic        safety_ok;
		logic        servo_ready;
		logic        servo_on;
		logic [11:0] alarm_code;
		logic [7:0]  ip_octet4;
	} sic_status_t;

endpackage

// ==== tb/sic_panel_model.sv ====
// Panel model: the display and the fault lamp as a viewer sees them.
`timescale 1ns/100ps
module sic_panel_model import sic_pkg::*; (
	input  logic            ref_clk,
	input  logic            clear,
	input  logic [2:0][4:0] disp_char,
	input  logic            fault_network_led,
	output int              toggles,
	output logic [4:0]      top_char
);
	logic last_fault;  // Fault lamp level seen at the previous edge.

	// The top digit is what the viewer reads first.
	assign top_char = disp_char[2];

	// Count every visible change of the fault lamp since the last clear.
	always @(posedge ref_clk) begin
		last_fault <= fault_network_led;
		if (clear) begin
			toggles <= 0;
		end else if (fault_network_led !== last_fault) begin
			toggles <= toggles + 1;
		end
	end
endmodule

// ==== tb/status_indicator_control_tb.sv ====
// Self-checking bench for the status indicator controller.
`timescale 1ns/100ps
module status_indicator_control_tb import sic_pkg::*;;
	logic            ref_clk = 1'b0;
	logic            resetn  = 1'b0;
	sic_status_t     st      = '0;      // Status levels into the block.
	sic_status_t     s, base;           // Working and normal-run status.
	logic [1:0]      plink   = '0;      // Port link pins.
	logic [1:0]      perr    = '0;      // Port line-error pins.
	logic [7:0]      addr    = '0;
	logic [31:0]     wdata   = '0;
	logic            wr      = 1'b0;
	logic            rd      = 1'b0;
	logic            clr     = 1'b0;    // Clears the model's lamp count.
	logic [31:0]     rdata, d;
	logic            irq, op_led, flt_led, safety_ready_led_led;
	logic [2:0][4:0] dchar;
	logic [2:0]      dp;
	logic [1:0]      lnk_led, le_led;
	logic [4:0]      top, ex;
	int              tog, n_errors, total_checks, cycles;

	// The 40 MHz clock.
	always #12.5 ref_clk = ~ref_clk;

	// Short tick so that blink and dwell fit in a short run.
	sic_top #(.DIGITS(3), .NPORTS(2), .TICK_CYCLES(4)) i_dut (
		.ref_clk(ref_clk), .resetn(resetn), .status(st),
		.port_link(plink), .port_line_err(perr), .bus_addr(addr),
		.bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
		.irq(irq), .disp_char(dchar), .disp_dp(dp),
		.operating_led(op_led), .fault_network_led(flt_led),
		.safety_ready_led(safety_ready_led_led), .link_led(lnk_led),
		.line_error_led(le_led));

	sic_panel_model i_panel (
		.ref_clk(ref_clk), .clear(clr), .disp_char(dchar),
		.fault_network_led(flt_led), .toggles(tog), .top_char(top));

	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// A hang is cut short well past the expected run length.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles >= 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Lets n edges pass, then samples settled values.
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// One-cycle register write.
	task automatic bw(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	// One-cycle register read; data stand only in the next cycle.
	task automatic br(input logic [7:0] a);
		@(posedge ref_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Applies a new status word at a clock edge.
	task automatic setst(input sic_status_t v);
		@(posedge ref_clk);
		st <= v;
	endtask

	// Boot view holds until the check ends and the amplifier starts.
	task automatic t_boot;
		step(3);
		chk("boot char", SIC_CH_BOOT, top);
		s = base;
		s.amp_started = 1'b0;
		setst(s);
		step(4);
		chk("boot wait", SIC_CH_BOOT, top);
		setst(base);
		step(3);
		br(SIC_STATE);
		chk("net view", 32'h1, d[1:0]);
		chk("online", SIC_CH_ONLINE, top);
		chk("ip high", 32'h0c, dchar[1]);
		chk("ip low", 32'h05, dchar[0]);
		br(SIC_INT_STAT);
		chk("ready int", 32'h1, d[SIC_INT_READY]);
		bw(SIC_INT_STAT, 32'h1f);
		$display("test boot done");
	endtask

	// Each new state outranks the previous one, so priority is covered.
	task automatic t_patterns;
		s = base;
		for (int i = 0; i < 10; i++) begin
			case (i)
				0: begin
					s.nm_safeop = 1'b1;
					ex = SIC_CH_SAFEOP;
				end
				1: begin
					s.nm_preop = 1'b1;
					ex = SIC_CH_PREOP;
				end
				2: begin
					s.reserved_stn = 1'b1;
					ex = SIC_CH_RSVD;
				end
				3: begin
					s.data_linked = 1'b0;
					ex = SIC_CH_NOLINK;
				end
				4: begin
					s.ctrl_connected = 1'b0;
					ex = SIC_CH_NOCTRL;
				end
				5: begin
					s.test_mode = 1'b1;
					ex = SIC_CH_TEST;
				end
				6: begin
					s.ip_setting = 1'b1;
					ex = SIC_CH_IPSET;
				end
				7: begin
					s.param_init = 1'b1;
					ex = SIC_CH_INIT;
				end
				8: begin
					s.fw_updating = 1'b1;
					ex = SIC_CH_UPDATE;
				end
				default: begin
					s.cpu_wdt_err = 1'b1;
					ex = SIC_CH_CPUERR;
				end
			endcase
			setst(s);
			step(3);
			chk("pattern", ex, top);
			chk("filler", SIC_CH_DASH, dchar[0]);
		end
		setst(base);
		$display("test patterns done");
	endtask

	// Decimal points follow the servo state alone.
	task automatic t_points;
		for (int j = 0; j < 4; j++) begin
			s = base;
			s.servo_on = j[0];
			s.servo_ready = j[1];
			setst(s);
			step(3);
			chk("points", {j[1], j[0]}, dp);
			chk("points chars", SIC_CH_ONLINE, top);
		end
		$display("test points done");
	endtask

	// Port lamps follow their pins after the synchroniser.
	task automatic t_ports;
		for (int j = 0; j < 4; j++) begin
			@(posedge ref_clk);
			plink <= j[1:0];
			perr <= ~j[1:0];
			step(8);
			chk("link lamp", j[1:0], lnk_led);
			chk("error lamp", {~j[1:0]}, le_led);
		end
		br(SIC_INT_STAT);
		chk("link ints", 32'h3, d[3:2]);
		bw(SIC_INT_STAT, 32'h1f);
		$display("test ports done");
	endtask

	// Alarm lamps, masked interrupt and the alternating alarm view.
	task automatic t_alarm;
		bit seen;
		seen = 1'b0;
		s = base;
		s.safety_ok = 1'b1;
		setst(s);
		step(3);
		chk("run lamp on", 32'h1, op_led);
		chk("fault off", 32'h0, flt_led);
		chk("safety on", 32'h1, safety_ready_led_led);
		s.alarm = 1'b1;
		s.alarm_code = 12'h3a7;
		setst(s);
		step(3);
		chk("run lamp off", 32'h0, op_led);
		chk("fault on", 32'h1, flt_led);
		chk("irq masked", 32'h0, irq);
		bw(SIC_INT_MASK, 32'h1);
		step(2);
		chk("irq raised", 32'h1, irq);
		bw(SIC_INT_STAT, 32'h1);
		step(2);
		chk("irq cleared", 32'h0, irq);
		for (int k = 0; k < 4200 && !seen; k++) begin
			step(1);
			seen = (dchar === {5'h03, 5'h0a, 5'h07});
		end
		chk("alarm code", 32'h1, seen);
		setst(base);
		step(3);
		chk("back to net", SIC_CH_ONLINE, top);
		chk("safety off", 32'h0, safety_ready_led_led);
		$display("test alarm done");
	endtask

	// Restart parameter, warning blink and alarm priority.
	task automatic t_blink;
		bw(SIC_CFG_PEND, 32'h2);
		br(SIC_CFG_ACT);
		chk("cfg held", 32'h1f4, d[15:0]);
		bw(SIC_CTRL, 32'h1);
		br(SIC_CFG_ACT);
		chk("cfg applied", 32'h2, d[15:0]);
		step(4);
		s = base;
		s.warning = 1'b1;
		setst(s);
		step(3);
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		step(80);
		chk("blink count", 32'h1, tog >= 9 && tog <= 11);
		s.alarm = 1'b1;
		setst(s);
		step(3);
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		step(40);
		chk("steady count", 32'h0, tog);
		chk("steady on", 32'h1, flt_led);
		setst(base);
		step(3);
		chk("fault idle", 32'h0, flt_led);
		br(8'h40);
		chk("unmapped", 32'h0, d);
		br(SIC_CTRL);
		chk("ctrl reads", 32'h0, d);
		$display("test blink done");
	endtask

	// Main sequence.
	initial begin
		base = '0;
		base.sys_check_done = 1'b1;
		base.amp_started = 1'b1;
		base.amp_on = 1'b1;
		base.ctrl_connected = 1'b1;
		base.data_linked = 1'b1;
		base.ip_octet4 = 8'hc5;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		t_boot();
		t_patterns();
		t_points();
		t_ports();
		t_alarm();
		t_blink();
		tally_and_finish();
	end
endmodule
